/* File: design/acci_clk_select.sv */
/*
 * Conversion clock source choice and divider, as one-cycle ticks on clk.
 * Assumes slow sources run far below clk, as they are edge detected.
 */
`default_nettype none

module acci_clk_select
    import acci_pkg::*;
#(
    parameter int DIV_W = ACCI_DIV_W
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // Configuration
    input  wire logic [1:0]       source,
    input  wire logic [DIV_W-1:0] divide,
    input  wire logic [1:0]       power_mode,
    // Source signals
    input  wire logic             local_clock,
    input  wire logic             osc_clock,
    // Divided conversion clock tick
    output logic                  conv_tick
);

    localparam int CNT_W = (2 ** DIV_W) - 1;

    if (DIV_W < 1 || DIV_W > 4) begin : g_check
        $error("acci_clk_select: DIV_W must be 1 to 4");
    end

    logic             half_q;
    logic             local_prev_q;
    logic             osc_prev_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             tick_q;
    logic             tick_d;

    // Mode gating: bus clock stops in stop3, so do both bus sources
    wire in_stop3  = (power_mode == ACCI_PM_STOP3);
    wire bus_ok    = !in_stop3;
    wire alt_ok    = !in_stop3;
    wire local_edg = local_clock && !local_prev_q;
    wire osc_edg   = osc_clock && !osc_prev_q;

    // Source mux
    wire src_tick =
        (source == ACCI_CLK_BUS)   ? bus_ok :
        (source == ACCI_CLK_BUS2)  ? (bus_ok && half_q) :
        (source == ACCI_CLK_ALT)   ? (alt_ok && osc_edg) :
                                     local_edg;

    // Divide by 2**divide
    wire [CNT_W-1:0] limit = ({{(CNT_W-1){1'b0}}, 1'b1} << divide) - 1'b1;
    wire             wrap  = (cnt_q >= limit);
    assign cnt_d  = !src_tick ? cnt_q : (wrap ? '0 : cnt_q + 1'b1);
    assign tick_d = src_tick && wrap;

    // Divider and edge state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            half_q       <= 1'b0;
            local_prev_q <= 1'b0;
            osc_prev_q   <= 1'b0;
            cnt_q        <= '0;
            tick_q       <= 1'b0;
        end else begin
            half_q       <= !half_q;
            local_prev_q <= local_clock;
            osc_prev_q   <= osc_clock;
            cnt_q        <= cnt_d;
            tick_q       <= tick_d;
        end
    end

    assign conv_tick = tick_q;

endmodule

`default_nettype wire

/* File: design/acci_input_decode.sv */
/*
 * Converter input select decode, one line per source.
 * Assumes the caller registers the outputs.
 */
`default_nettype none

module acci_input_decode
    import acci_pkg::*;
(
    // Select code
    input  wire logic [ACCI_SEL_W-1:0] sel,
    // Decoded source lines
    output logic      [ACCI_N_EXT-1:0] ext_sel,
    output logic                       gnd_sel,
    output logic                       temp_sel,
    output logic                       bgap_sel,
    output logic                       vrefh_sel,
    output logic                       vrefl_sel,
    output logic                       off_sel,
    output logic                       rsvd_sel
);

    wire ext_range = (sel <= ACCI_SEL_EXT_HI);

    // One line per external input
    for (genvar i = 0; i < ACCI_N_EXT; i++) begin : g_ext
        assign ext_sel[i] = ext_range &&
            (sel == (ACCI_SEL_EXT_LO + ACCI_SEL_W'(i)));
    end

    // Internal sources
    assign gnd_sel   = (sel >= ACCI_SEL_GND_LO) &&
                       (sel <= ACCI_SEL_GND_HI);
    assign temp_sel  = (sel == ACCI_SEL_TEMP);
    assign bgap_sel  = (sel == ACCI_SEL_BGAP);
    assign vrefh_sel = (sel == ACCI_SEL_VREFH);
    assign vrefl_sel = (sel == ACCI_SEL_VREFL);
    assign off_sel   = (sel == ACCI_SEL_OFF);

    // Unclaimed codes connect nothing
    assign rsvd_sel  = !(ext_range || gnd_sel || temp_sel || bgap_sel ||
                         vrefh_sel || vrefl_sel || off_sel);

endmodule

`default_nettype wire

/* File: design/acci_pkg.sv */
/*
 * Shared codes, encodings and reset values of the interconnect.
 * Assumes importers take the whole package.
 */
`default_nettype none

package acci_pkg;

    // Converter input select field
    localparam int          ACCI_SEL_W      = 5;
    localparam int          ACCI_N_EXT      = 8;
    localparam logic [4:0]  ACCI_SEL_EXT_LO = 5'h00;
    localparam logic [4:0]  ACCI_SEL_EXT_HI = 5'h07;
    localparam logic [4:0]  ACCI_SEL_GND_LO = 5'h08;
    localparam logic [4:0]  ACCI_SEL_GND_HI = 5'h12;
    localparam logic [4:0]  ACCI_SEL_TEMP   = 5'h16;
    localparam logic [4:0]  ACCI_SEL_BGAP   = 5'h17;
    localparam logic [4:0]  ACCI_SEL_VREFH  = 5'h1D;
    localparam logic [4:0]  ACCI_SEL_VREFL  = 5'h1E;
    localparam logic [4:0]  ACCI_SEL_OFF    = 5'h1F;
    localparam logic [4:0]  ACCI_SEL_RST    = 5'h1F;

    // Conversion clock sources
    localparam logic [1:0]  ACCI_CLK_BUS    = 2'h0;
    localparam logic [1:0]  ACCI_CLK_BUS2   = 2'h1;
    localparam logic [1:0]  ACCI_CLK_ALT    = 2'h2;
    localparam logic [1:0]  ACCI_CLK_LOCAL  = 2'h3;
    localparam int          ACCI_DIV_W      = 2;

    // Hardware trigger sources
    localparam logic [1:0]  ACCI_TRG_RTC    = 2'h0;
    localparam logic [1:0]  ACCI_TRG_CMP    = 2'h1;
    localparam logic [1:0]  ACCI_TRG_TMR0   = 2'h2;
    localparam logic [1:0]  ACCI_TRG_TMR1   = 2'h3;

    // Power modes
    typedef enum logic [1:0] {
        ACCI_PM_RUN   = 2'b00,
        ACCI_PM_WAIT  = 2'b01,
        ACCI_PM_STOP3 = 2'b10
    } acci_pmode_t;

    // Comparator input mux
    localparam int          ACCI_CMP_N_IN   = 4;
    localparam logic [1:0]  ACCI_CMP_IN0    = 2'h0;
    localparam logic [1:0]  ACCI_CMP_IN1    = 2'h1;
    localparam logic [1:0]  ACCI_CMP_RSVD   = 2'h2;
    localparam logic [1:0]  ACCI_CMP_DAC    = 2'h3;

    // Comparator event edge modes
    localparam logic [1:0]  ACCI_EDGE_FALL  = 2'h0;
    localparam logic [1:0]  ACCI_EDGE_RISE  = 2'h1;
    localparam logic [1:0]  ACCI_EDGE_FALL2 = 2'h2;
    localparam logic [1:0]  ACCI_EDGE_BOTH  = 2'h3;

    // Reset values
    localparam logic        ACCI_FLAG_RST   = 1'b0;
    localparam logic        ACCI_PIN_RST    = 1'b0;

endpackage

`default_nettype wire

/* File: design/acci_top.sv */
/*
 * Converter and comparator glue: decode, clock, trigger, muxes, routing.
 * Assumes synchronous inputs; outputs lag their cause by one cycle.
 */
`default_nettype none

// Operation
// - Codes 0-7 external, 8-18 ground, 29-30 references, 31 off.
// - Reserved codes accepted; result undefined.
// - Clocks: bus, half bus, local, alternate.
// - Alternate clock is the oscillator output.
// - Alternate clock runs in wait.
// - Triggers: overflow, comparator, timers; run and wait.
// - Stop3: overflow trigger only.
// - Comparator inputs: A0, A1, reserved, DAC.
// - Comparator runs in stop3, drives pin if enabled.
// - Event with interrupt enable sets flag, wakes.
// - Capture route feeds timer1 channel 0, cuts pin.
// - Serial route feeds serial receive, pin ignored.
module acci_top
    import acci_pkg::*;
#(
    parameter int DIV_W = ACCI_DIV_W
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // Power mode
    input  wire logic [1:0]            power_mode,
    // Converter configuration
    input  wire logic [ACCI_SEL_W-1:0] converter_input_select,
    input  wire logic [1:0]            conv_clock_source,
    input  wire logic [DIV_W-1:0]      clock_divide_field,
    input  wire logic [1:0]            trigger_select,
    input  wire logic                  hw_trigger_enable,
    // Clock sources
    input  wire logic                  converter_local_async_clock,
    input  wire logic                  oscillator_output,
    // Trigger sources
    input  wire logic                  rtc_overflow,
    input  wire logic                  timer0_out,
    input  wire logic                  timer1_out,
    // Converter source selects
    output logic [ACCI_N_EXT-1:0]      ext_input_select,
    output logic                       ground_select,
    output logic                       temp_sensor_select,
    output logic                       bandgap_select,
    output logic                       vrefh_select,
    output logic                       vrefl_select,
    output logic                       converter_off,
    output logic                       result_undefined,
    // Converter clock and trigger
    output logic                       conversion_clock,
    output logic                       hw_trigger,
    // Comparator configuration
    input  wire logic                  comparator_enable,
    input  wire logic [1:0]            pos_input_select,
    input  wire logic [1:0]            neg_input_select,
    input  wire logic [1:0]            cmp_edge_mode,
    input  wire logic                  comparator_interrupt_enable,
    input  wire logic                  comparator_output_pin_enable,
    input  wire logic                  comparator_event_flag_clear,
    input  wire logic                  comparator_to_capture_route,
    input  wire logic                  comparator_to_serial_route,
    // Comparator analog side
    input  wire logic                  comparator_result,
    output logic [ACCI_CMP_N_IN-1:0]   pos_input_onehot,
    output logic [ACCI_CMP_N_IN-1:0]   neg_input_onehot,
    // Comparator status
    output logic                       comparator_event_flag,
    output logic                       comparator_irq,
    output logic                       stop_wakeup,
    // Comparator output pin
    output logic                       comparator_output_pin,
    output logic                       comparator_output_pin_oe,
    // Timer 1 channel 0
    input  wire logic                  timer1_channel0_pin_in,
    input  wire logic                  timer1_ch0_drive,
    input  wire logic                  timer1_ch0_drive_oe,
    output logic                       timer1_channel0_pin_out,
    output logic                       timer1_channel0_pin_oe,
    output logic                       timer1_capture_in,
    // Serial port 0 receive
    input  wire logic                  serial_rx_pin,
    output logic                       serial_port0_rx
);

    if (DIV_W < 1 || DIV_W > 4) begin : g_check
        $error("acci_top: DIV_W must be 1 to 4");
    end

    // Decoder outputs
    logic [ACCI_N_EXT-1:0] dec_ext;
    logic                  dec_gnd;
    logic                  dec_temp;
    logic                  dec_bgap;
    logic                  dec_vrefh;
    logic                  dec_vrefl;
    logic                  dec_off;
    logic                  dec_rsvd;

    // Registered converter selects
    logic [ACCI_N_EXT-1:0] ext_q;
    logic                  gnd_q;
    logic                  temp_q;
    logic                  bgap_q;
    logic                  vrefh_q;
    logic                  vrefl_q;
    logic                  off_q;
    logic                  rsvd_q;

    // Trigger state
    logic                  trg_prev_q;
    logic                  trg_q;

    // Comparator state
    logic [ACCI_CMP_N_IN-1:0] pos_q;
    logic [ACCI_CMP_N_IN-1:0] neg_q;
    logic                  cmp_prev_q;
    logic                  flag_q;
    logic                  flag_d;
    logic                  irq_q;
    logic                  wake_q;
    logic                  pin_q;
    logic                  pin_oe_q;
    logic                  t1_out_q;
    logic                  t1_oe_q;
    logic                  t1_cap_q;
    logic                  rx_q;

    // Input select decode
    acci_input_decode u_decode (
        .sel       (converter_input_select),
        .ext_sel   (dec_ext),
        .gnd_sel   (dec_gnd),
        .temp_sel  (dec_temp),
        .bgap_sel  (dec_bgap),
        .vrefh_sel (dec_vrefh),
        .vrefl_sel (dec_vrefl),
        .off_sel   (dec_off),
        .rsvd_sel  (dec_rsvd)
    );

    // Conversion clock source and divider
    acci_clk_select #(
        .DIV_W (DIV_W)
    ) u_clk (
        .clk         (clk),
        .nrst        (nrst),
        .source      (conv_clock_source),
        .divide      (clock_divide_field),
        .power_mode  (power_mode),
        .local_clock (converter_local_async_clock),
        .osc_clock   (oscillator_output),
        .conv_tick   (conversion_clock)
    );

    // Mode and comparator level
    wire in_stop3 = (power_mode == ACCI_PM_STOP3);
    wire cmp_out  = comparator_enable && comparator_result;

    // Trigger source mux; only the counter overflow survives stop3
    wire trg_raw =
        (trigger_select == ACCI_TRG_RTC)  ? rtc_overflow :
        (trigger_select == ACCI_TRG_CMP)  ? cmp_out :
        (trigger_select == ACCI_TRG_TMR0) ? timer0_out :
                                            timer1_out;
    wire trg_allowed = !in_stop3 ||
                       (trigger_select == ACCI_TRG_RTC);
    wire trg_src = hw_trigger_enable && trg_allowed && trg_raw;
    wire trg_d   = trg_src && !trg_prev_q;

    // Comparator input muxes; the reserved leg connects nothing
    for (genvar i = 0; i < ACCI_CMP_N_IN; i++) begin : g_cmp_mux
        wire usable = (2'(i) != ACCI_CMP_RSVD);
        wire pos_hit = comparator_enable && usable &&
                       (pos_input_select == 2'(i));
        wire neg_hit = comparator_enable && usable &&
                       (neg_input_select == 2'(i));
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                pos_q[i] <= 1'b0;
                neg_q[i] <= 1'b0;
            end else begin
                pos_q[i] <= pos_hit;
                neg_q[i] <= neg_hit;
            end
        end
    end

    // Compare event detection by edge mode
    wire cmp_rise  = cmp_out && !cmp_prev_q;
    wire cmp_fall  = !cmp_out && cmp_prev_q;
    wire cmp_event = comparator_enable && (
        (cmp_edge_mode == ACCI_EDGE_RISE) ? cmp_rise :
        (cmp_edge_mode == ACCI_EDGE_BOTH) ? (cmp_rise || cmp_fall) :
                                            cmp_fall);

    // Flag: a new event beats a clear in the same cycle
    wire flag_set = cmp_event && comparator_interrupt_enable;
    assign flag_d = flag_set ||
                    (flag_q && !comparator_event_flag_clear);
    wire wake_d   = flag_set && in_stop3;
    wire irq_d    = flag_d && comparator_interrupt_enable;

    // Pin follows the comparator in every mode
    wire pin_d    = comparator_output_pin_enable && cmp_out;
    wire pin_oe_d = comparator_output_pin_enable;

    // Timer 1 channel 0: the route takes the capture and the pin away
    wire t1_cap_d = comparator_to_capture_route ?
                    cmp_out : timer1_channel0_pin_in;
    wire t1_oe_d  = !comparator_to_capture_route &&
                    timer1_ch0_drive_oe;
    wire t1_out_d = t1_oe_d && timer1_ch0_drive;

    // Serial receive: external pin ignored while routed
    wire rx_d = comparator_to_serial_route ?
                cmp_out : serial_rx_pin;

    // Converter select registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_q   <= '0;
            gnd_q   <= 1'b0;
            temp_q  <= 1'b0;
            bgap_q  <= 1'b0;
            vrefh_q <= 1'b0;
            vrefl_q <= 1'b0;
            off_q   <= 1'b1; // Converter idle until configured
            rsvd_q  <= 1'b0;
        end else begin
            ext_q   <= dec_ext;
            gnd_q   <= dec_gnd;
            temp_q  <= dec_temp;
            bgap_q  <= dec_bgap;
            vrefh_q <= dec_vrefh;
            vrefl_q <= dec_vrefl;
            off_q   <= dec_off;
            rsvd_q  <= dec_rsvd;
        end
    end

    // Trigger registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trg_prev_q <= 1'b0;
            trg_q      <= 1'b0;
        end else begin
            trg_prev_q <= trg_src;
            trg_q      <= trg_d;
        end
    end

    // Comparator status registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmp_prev_q <= 1'b0;
            flag_q     <= ACCI_FLAG_RST;
            irq_q      <= 1'b0;
            wake_q     <= 1'b0;
        end else begin
            cmp_prev_q <= cmp_out;
            flag_q     <= flag_d;
            irq_q      <= irq_d;
            wake_q     <= wake_d;
        end
    end

    // Routed output registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_q    <= ACCI_PIN_RST;
            pin_oe_q <= 1'b0;
            t1_out_q <= 1'b0;
            t1_oe_q  <= 1'b0;
            t1_cap_q <= 1'b0;
            rx_q     <= 1'b1; // Serial line idles high
        end else begin
            pin_q    <= pin_d;
            pin_oe_q <= pin_oe_d;
            t1_out_q <= t1_out_d;
            t1_oe_q  <= t1_oe_d;
            t1_cap_q <= t1_cap_d;
            rx_q     <= rx_d;
        end
    end

    // Port drives
    assign ext_input_select = ext_q;
    assign ground_select = gnd_q;
    assign temp_sensor_select = temp_q;
    assign bandgap_select = bgap_q;
    assign vrefh_select = vrefh_q;
    assign vrefl_select = vrefl_q;
    assign converter_off = off_q;
    assign result_undefined = rsvd_q;
    assign hw_trigger = trg_q;
    assign pos_input_onehot = pos_q;
    assign neg_input_onehot = neg_q;
    assign comparator_event_flag = flag_q;
    assign comparator_irq = irq_q;
    assign stop_wakeup = wake_q;
    assign comparator_output_pin = pin_q;
    assign comparator_output_pin_oe = pin_oe_q;
    assign timer1_channel0_pin_out = t1_out_q;
    assign timer1_channel0_pin_oe = t1_oe_q;
    assign timer1_capture_in = t1_cap_q;
    assign serial_port0_rx = rx_q;

endmodule

`default_nettype wire

/* File: dv/acci_checker.sv */
/*
 * Checks on the top's ports.
 * Assumes binding into acci_top.
 */
`default_nettype none
module acci_checker
    import acci_pkg::*;
#(
    parameter int DIV_W = ACCI_DIV_W
) (
    // Clock, reset, configuration
    input wire logic clk, nrst,
    input wire logic [1:0] power_mode, conv_clock_source, trigger_select,
    input wire logic [1:0] pos_input_select, cmp_edge_mode,
    input wire logic [DIV_W-1:0] clock_divide_field,
    input wire logic [ACCI_SEL_W-1:0] converter_input_select,
    input wire logic comparator_enable, comparator_interrupt_enable,
    input wire logic comparator_result, comparator_output_pin_enable,
    input wire logic comparator_to_capture_route, comparator_to_serial_route,
    // Design outputs
    input wire logic [ACCI_N_EXT-1:0] ext_input_select,
    input wire logic [ACCI_CMP_N_IN-1:0] pos_input_onehot,
    input wire logic converter_off, result_undefined, conversion_clock,
    input wire logic hw_trigger, comparator_event_flag, stop_wakeup,
    input wire logic comparator_output_pin, comparator_output_pin_oe,
    input wire logic timer1_channel0_pin_oe, timer1_capture_in,
    input wire logic serial_port0_rx
);
    timeunit 1ns;
    timeprecision 1ps;
    // One clock domain, quiet while in reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Decode, clock, trigger
    property p_ext; converter_input_select <= 5'h07 |=>
        ext_input_select == 8'h01 << $past(converter_input_select); endproperty
    a_ext: assert property (p_ext) else $error("ext select wrong");
    property p_rsvd; converter_input_select inside {[5'h13:5'h15],
        [5'h18:5'h1C]} |=> result_undefined && !converter_off; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved code");
    property p_bus; (conv_clock_source == ACCI_CLK_BUS && power_mode ==
        ACCI_PM_RUN && clock_divide_field == 0)[*2] |=> conversion_clock;
    endproperty
    a_bus: assert property (p_bus) else $error("bus clock tick lost");
    property p_trs; power_mode == ACCI_PM_STOP3 && trigger_select !=
        ACCI_TRG_RTC |=> !hw_trigger; endproperty
    a_trs: assert property (p_trs) else $error("stop3 trigger");
    // Comparator
    property p_flg; comparator_interrupt_enable && comparator_enable &&
        $past(comparator_enable) && cmp_edge_mode == ACCI_EDGE_RISE &&
        $rose(comparator_result) |=> comparator_event_flag &&
        stop_wakeup == ($past(power_mode) == ACCI_PM_STOP3); endproperty
    a_flg: assert property (p_flg) else $error("event flag missed");
    property p_pin; 1'b1 |=> comparator_output_pin_oe ==
        $past(comparator_output_pin_enable) && comparator_output_pin ==
        $past(comparator_output_pin_enable && comparator_enable &&
        comparator_result); endproperty
    a_pin: assert property (p_pin) else $error("output pin wrong");
    property p_cap; comparator_to_capture_route |=> !timer1_channel0_pin_oe
        && timer1_capture_in == $past(comparator_enable && comparator_result);
    endproperty
    a_cap: assert property (p_cap) else $error("capture route");
    property p_rx; comparator_to_serial_route |=> serial_port0_rx ==
        $past(comparator_enable && comparator_result); endproperty
    a_rx: assert property (p_rx) else $error("serial route");
    property p_mux; comparator_enable |=> pos_input_onehot == ($past(
        pos_input_select) == ACCI_CMP_RSVD ? 4'h0 : 4'h1 <<
        $past(pos_input_select)); endproperty
    a_mux: assert property (p_mux) else $error("input mux wrong");
endmodule
`default_nettype wire

/* File: dv/acci_src_model.sv */
/*
 * Far side: oscillator and local converter clock as slow square waves.
 * Assumes clk is the bus clock; both rates stay far below it.
 */
`default_nettype none
module acci_src_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Slow clocks
    output logic      oscillator_output,
    output logic      converter_local_async_clock
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q;
    // Moves on the falling edge, away from the sampling edge
    always_ff @(negedge clk or negedge nrst) begin
        if (!nrst) cnt_q <= 4'h0;
        else cnt_q <= cnt_q + 4'h1;
    end
    // Oscillator period 8 cycles, local clock 16
    assign oscillator_output = cnt_q[2];
    assign converter_local_async_clock = cnt_q[3];
endmodule
`default_nettype wire

/* File: dv/acci_top_bench.sv */
/*
 * Self-checking bench of the converter and comparator interconnect.
 * Assumes the source model supplies both slow clock inputs.
 */
`default_nettype none
module acci_top_bench
    import acci_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Design inputs, quiet at time zero
    logic clk = '0, nrst = '0, hw_trigger_enable = '0, rtc_overflow = '0;
    logic [1:0] power_mode = '0, conv_clock_source = '0, trigger_select = '0;
    logic [1:0] clock_divide_field = '0, cmp_edge_mode = '0;
    logic [1:0] pos_input_select = '0, neg_input_select = '0;
    logic [4:0] converter_input_select = '0;
    logic timer0_out = '0, timer1_out = '0, comparator_enable = '0;
    logic comparator_result = '0, comparator_interrupt_enable = '0;
    logic comparator_output_pin_enable = '0, comparator_event_flag_clear = '0;
    logic comparator_to_capture_route = '0, comparator_to_serial_route = '0;
    logic timer1_channel0_pin_in = '0, timer1_ch0_drive = '0;
    logic timer1_ch0_drive_oe = '0, serial_rx_pin = '0;
    // Design and model outputs
    logic [7:0] ext_input_select;
    logic [3:0] pos_input_onehot, neg_input_onehot;
    logic ground_select, temp_sensor_select, bandgap_select, vrefh_select;
    logic vrefl_select, converter_off, result_undefined, conversion_clock;
    logic hw_trigger, comparator_event_flag, comparator_irq, stop_wakeup;
    logic comparator_output_pin, comparator_output_pin_oe, timer1_capture_in;
    logic timer1_channel0_pin_out, timer1_channel0_pin_oe, serial_port0_rx;
    logic converter_local_async_clock, oscillator_output;
    int errors = 0, cmp_count = 0, cyc = 0;
    acci_top #(.DIV_W(2)) i_acci_top (.*);
    acci_src_model i_acci_src_model (.*);
    // Bus clock, 10 ns period
    initial begin
        forever #5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            stop_test();
        end
    end
    task automatic nc(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // All select codes
    task automatic t_decode();
        logic [4:0] s;
        for (int c = 0; c < 32; c++) begin
            s = c[4:0];
            converter_input_select = s;
            nc(1);
            check("decode", {1'h0, ext_input_select, ground_select,
                temp_sensor_select, bandgap_select, vrefh_select, vrefl_select,
                converter_off, result_undefined}, {1'h0, s < 5'h08 ? 8'h01 << s
                : 8'h00, s inside {[5'h08:5'h12]}, s == 5'h16, s == 5'h17,
                s == 5'h1D, s == 5'h1E, s == 5'h1F, s inside {[5'h13:5'h15],
                [5'h18:5'h1C]}});
        end
    endtask
    // Source and mode table; counts allow one tick of phase slip
    task automatic t_clock();
        logic [3:0] sp [6] = '{4'h0, 4'h4, 4'h9, 4'hE, 4'hA, 4'h2};
        int en [6] = '{64, 32, 8, 4, 0, 0};
        int n;
        clock_divide_field = 2'h1;
        for (int i = 0; i < 6; i++) begin
            {conv_clock_source, power_mode} = sp[i];
            nc(4);
            n = 0;
            repeat (128) begin
                nc(1);
                n += (conversion_clock === 1'b1);
            end
            check("clock", 16'(n > en[i] - 2 && n < en[i] + 2),
                16'h1);
        end
        power_mode = ACCI_PM_RUN;
    endtask
    // Each trigger, run then stop3
    task automatic t_trigger();
        int n;
        hw_trigger_enable = 1'b1;
        comparator_enable = 1'b1;
        for (int i = 0; i < 8; i++) begin
            trigger_select = i[1:0];
            power_mode = i[2] ? ACCI_PM_STOP3 : ACCI_PM_RUN;
            nc(2);
            {timer1_out, timer0_out, comparator_result, rtc_overflow}
                = 4'h1 << i[1:0];
            n = 0;
            repeat (3) begin
                nc(1);
                n += (hw_trigger === 1'b1);
            end
            {timer1_out, timer0_out, comparator_result, rtc_overflow} = 4'h0;
            check("trigger", 16'(n), 16'(i < 5));
        end
        power_mode = ACCI_PM_RUN;
    endtask
    // Flag, wake-up, routing, muxes
    task automatic t_cmp();
        cmp_edge_mode = ACCI_EDGE_RISE;
        comparator_result = 1'b1;
        nc(2);
        check("flag_masked", 16'(comparator_event_flag), 16'h0);
        {comparator_result, power_mode} = {1'b0, ACCI_PM_STOP3};
        {comparator_interrupt_enable, comparator_output_pin_enable,
            comparator_to_capture_route, comparator_to_serial_route,
            timer1_ch0_drive_oe} = 5'h1F;
        nc(2);
        comparator_result = 1'b1;
        nc(1);
        check("wake", {9'h0, comparator_event_flag, comparator_irq, stop_wakeup,
            comparator_output_pin, comparator_output_pin_oe, timer1_capture_in,
            serial_port0_rx}, 16'h7F);
        check("pin_cut", 16'({timer1_channel0_pin_oe,
            timer1_channel0_pin_out}), 16'h0);
        comparator_event_flag_clear = 1'b1;
        nc(1);
        comparator_event_flag_clear = 1'b0;
        cmp_edge_mode = ACCI_EDGE_FALL;
        nc(1);
        check("cleared", 16'(comparator_event_flag), 16'h0);
        comparator_result = 1'b0;
        nc(1);
        check("fall", 16'(comparator_event_flag), 16'h1);
        for (int i = 0; i < 4; i++) begin
            {pos_input_select, neg_input_select} = {i[1:0], ~i[1:0]};
            nc(1);
            check("mux", {8'h0, pos_input_onehot, neg_input_onehot}, {8'h0,
                i == 2 ? 4'h0 : 4'h1 << i, i == 1 ? 4'h0 : 4'h8 >> i});
        end
        {comparator_to_capture_route, comparator_to_serial_route} = 2'h0;
        {timer1_ch0_drive, timer1_channel0_pin_in} = 2'h3;
        nc(1);
        check("unrouted", {12'h0, timer1_channel0_pin_oe,
            timer1_channel0_pin_out, timer1_capture_in, serial_port0_rx},
            16'hE);
    endtask
    // Reset, then each scenario
    initial begin
        nc(4);
        nrst = 1'b1;
        nc(1);
        t_decode();
        t_clock();
        t_trigger();
        t_cmp();
        stop_test();
    end
endmodule
bind acci_top acci_checker #(.DIV_W(DIV_W)) i_acci_checker (.*);
`default_nettype wire
